// *** sarcc_device.sv ***
// Converter end: start logic, successive approximation sequencer, latch and done flag
// Functional notes
// - Select and start low set start flop
// - Start flop clears shifter, done; loads one
// - Start falling edge clears approximation and shifter
// - Held start keeps converter in reset
// - Phase pulse with strobes released starts conversion
// - Phase pulse under held start does nothing
// - Start one to eight clocks after release
// - MSB first, eight comparisons, 64 clocks
// - Straight binary result, all ones full scale
// - Latch result first, then assert done
// - Latch updates one clock before done
// - New start aborts running conversion
// - Free run: select low, done fed back
// - Host pulses start once after power-up
// - Host reads eight clocks after done
// - Select and read low clear done, enable data
// - Read cannot clear done for eight clocks after set
// - Free-run fed back done restarts, short pulse
`timescale 1ns/1ps
module sarcc_device #(
    parameter logic [7:0] CONV_DIV = sarcc_pkg::CONV_DIV
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    sarcc_if.dev bus,
    input wire logic cmp_above_in,
    output logic [7:0] trial_code_out,
    output logic busy_out
);
    // ------------------------------------------------------------------
    // Pin synchronisers: three flops, change taken when stages two and three agree
    // ------------------------------------------------------------------
    logic [2:0] cs_s_r, wr_s_r, rd_s_r;
    logic cs_n_r, start_n_r, rd_n_r;
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cs_s_r <= 3'h7;
            wr_s_r <= 3'h7;
            rd_s_r <= 3'h7;
        end else begin
            cs_s_r <= {cs_s_r[1:0], bus.cs_n};
            wr_s_r <= {wr_s_r[1:0], bus.start_n};
            rd_s_r <= {rd_s_r[1:0], bus.rd_n};
        end
    end
    // Filtered levels only move when the two later stages agree
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cs_n_r <= 1'b1;
            start_n_r <= 1'b1;
            rd_n_r <= 1'b1;
        end else begin
            if (cs_s_r[1] == cs_s_r[2]) cs_n_r <= cs_s_r[2];
            if (wr_s_r[1] == wr_s_r[2]) start_n_r <= wr_s_r[2];
            if (rd_s_r[1] == rd_s_r[2]) rd_n_r <= rd_s_r[2];
        end
    end
    logic set_req, start_fall, read_sel, start_n_d_r;
    assign set_req = !cs_n_r && !start_n_r;
    assign read_sel = !cs_n_r && !rd_n_r;
    assign start_fall = start_n_d_r && !start_n_r;
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) start_n_d_r <= 1'b1;
        else start_n_d_r <= start_n_r;
    end

    // ------------------------------------------------------------------
    // Conversion clock and internal phase clock enables
    // ------------------------------------------------------------------
    logic [7:0] div_r;
    logic [2:0] phase_r;
    logic conv_tick, phase_tick;
    assign conv_tick = (div_r == CONV_DIV - 8'h01);
    assign phase_tick = conv_tick && (phase_r == sarcc_pkg::PHASE_DIV);
    // Phase counter free runs, so start lands 1 to 8 conversion clocks late
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_r <= 8'h00;
            phase_r <= 3'h0;
        end else if (conv_tick) begin
            div_r <= 8'h00;
            phase_r <= phase_r + 3'h1;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Start flop and head stage flop
    // ------------------------------------------------------------------
    logic start_ff_r, head_stage_flop_r, start_clear_gate;
    // Gate: head flop output with phase pulse clears the start flop
    assign start_clear_gate = head_stage_flop_r && phase_tick;
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) start_ff_r <= 1'b0;
        else if (set_req) start_ff_r <= 1'b1;
        else if (start_clear_gate) start_ff_r <= 1'b0;
    end
    // Set dominates clear, so a held start keeps the reset state
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) head_stage_flop_r <= 1'b0;
        else if (!start_ff_r) head_stage_flop_r <= 1'b0;
        else if (phase_tick) head_stage_flop_r <= 1'b1;
    end

    // ------------------------------------------------------------------
    // Sequencing shift register and approximation register
    // ------------------------------------------------------------------
    logic [8:0] seq_r;
    logic [7:0] approx_register_r;
    logic [7:0] result_r;
    logic done_set;
    logic head_q_pend_r;
    // The token walks one stage per phase tick; nine stages so the last
    // stage marks the latch transfer after the eighth comparison
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            seq_r <= 9'h000;
            approx_register_r <= 8'h00;
        end else if (start_ff_r || start_fall) begin
            seq_r <= 9'h000;
            if (start_fall) approx_register_r <= 8'h00;
        end else if (phase_tick) begin
            seq_r <= {seq_r[7:0], 1'b0};
            if (!head_stage_flop_r && seq_r == 9'h000 && start_clear_gate == 1'b0
                && head_q_pend_r) begin
                seq_r <= 9'h001;
                approx_register_r <= 8'h80;
            end
            // Each of the first seven stages resolves one bit and trials the next lower one
            for (int i = 0; i < 7; i++) begin
                if (seq_r[i]) begin
                    approx_register_r[7 - i] <= cmp_above_in;
                    approx_register_r[6 - i] <= 1'b1;
                end
            end
            // Eighth stage decides the LSB and has no lower bit to trial
            if (seq_r[7]) approx_register_r[0] <= cmp_above_in;
        end
    end
    // Remembers that the start flop was just released with the head flop set
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) head_q_pend_r <= 1'b0;
        else if (start_ff_r && start_clear_gate && !set_req) head_q_pend_r <= 1'b1;
        else if (start_ff_r || phase_tick) head_q_pend_r <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Output latch and done flag
    // ------------------------------------------------------------------
    logic latched_r;
    logic [3:0] hold_r;
    logic done_r;
    // Latch on the last stage; done follows one conversion clock later
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            result_r <= 8'h00;
            latched_r <= 1'b0;
        end else if (phase_tick && seq_r[8]) begin
            result_r <= approx_register_r;
            latched_r <= 1'b1;
        end else if (conv_tick || start_ff_r) begin
            latched_r <= 1'b0;
        end
    end
    assign done_set = latched_r && conv_tick && !start_ff_r;
    // Set wins over a read clear; a read cannot clear done for eight conversion clocks after set
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_r <= 1'b0;
            hold_r <= 4'h0;
        end else if (done_set) begin
            done_r <= 1'b1;
            hold_r <= sarcc_pkg::DONE_HOLD;
        end else begin
            if (hold_r != 4'h0 && conv_tick) hold_r <= hold_r - 4'h1;
            if (start_ff_r) begin
                done_r <= 1'b0;
                hold_r <= 4'h0;
            end else if (read_sel && hold_r == 4'h0) begin
                done_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registered pin drivers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bus.done_flag_n <= 1'b1;
            bus.data_o <= 8'h00;
            bus.data_oe_n <= 8'hff;
            trial_code_out <= 8'h00;
            busy_out <= 1'b0;
        end else begin
            bus.done_flag_n <= !done_r;
            bus.data_o <= result_r;
            bus.data_oe_n <= read_sel ? 8'h00 : 8'hff;
            trial_code_out <= approx_register_r;
            busy_out <= start_ff_r || (seq_r != 9'h000) || head_q_pend_r;
        end
    end
endmodule : sarcc_device

// *** sarcc_host.sv ***
// Host end: drives select, start and read strobes, reads the result
`timescale 1ns/1ps
module sarcc_host #(
    parameter logic [7:0] CONV_DIV = sarcc_pkg::CONV_DIV,
    // Strobes must outlast the far end's synchroniser so read data is driven when taken
    parameter logic [7:0] PULSE_CYC = 8'h10
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    sarcc_if.host bus,
    input wire logic start_req_in,
    input wire logic free_run_in,
    output logic [7:0] result_out,
    output logic result_valid_out
);
    // ------------------------------------------------------------------
    // Done flag synchroniser and conversion clock enable
    // ------------------------------------------------------------------
    logic [2:0] dn_s_r;
    logic done_n_r, boot_r;
    logic [7:0] div_r, cnt_r;
    logic [3:0] guard_r;
    logic conv_tick;
    sarcc_pkg::sarcc_hstate_type st_r;
    assign conv_tick = (div_r == CONV_DIV - 8'h01);
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dn_s_r <= 3'h7;
            done_n_r <= 1'b1;
            div_r <= 8'h00;
        end else begin
            dn_s_r <= {dn_s_r[1:0], bus.done_flag_n};
            if (dn_s_r[1] == dn_s_r[2]) done_n_r <= dn_s_r[2];
            div_r <= conv_tick ? 8'h00 : div_r + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Strobe sequencer: one boot start pulse, then starts, guarded reads
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r <= sarcc_pkg::SARCC_HS_IDLE;
            boot_r <= 1'b1;
            cnt_r <= 8'h00;
            guard_r <= 4'h0;
            bus.cs_n <= 1'b1;
            bus.start_n <= 1'b1;
            bus.rd_n <= 1'b1;
            result_out <= 8'h00;
            result_valid_out <= 1'b0;
        end else begin
            result_valid_out <= 1'b0;
            if (done_n_r) guard_r <= 4'h0;
            else if (conv_tick && guard_r != sarcc_pkg::READ_GUARD) guard_r <= guard_r + 4'h1;
            case (st_r)
                sarcc_pkg::SARCC_HS_IDLE: begin
                    bus.cs_n <= free_run_in ? 1'b0 : 1'b1;
                    if (boot_r || start_req_in) begin
                        // Power-up pulse; also a restart, which aborts a conversion
                        boot_r <= 1'b0;
                        bus.cs_n <= 1'b0;
                        bus.start_n <= 1'b0;
                        cnt_r <= PULSE_CYC;
                        st_r <= sarcc_pkg::SARCC_HS_START;
                    end else if (!done_n_r && guard_r == sarcc_pkg::READ_GUARD) begin
                        bus.cs_n <= 1'b0;
                        bus.rd_n <= 1'b0;
                        guard_r <= 4'h0; // Stale done level must not bring a second read
                        cnt_r <= PULSE_CYC;
                        st_r <= sarcc_pkg::SARCC_HS_READ;
                    end else begin
                        // Free run: select held low, done fed back as start; else start idles high
                        bus.start_n <= done_n_r || !free_run_in;
                    end
                end
                sarcc_pkg::SARCC_HS_START: begin
                    if (cnt_r == 8'h00) begin
                        bus.start_n <= 1'b1;
                        bus.cs_n <= free_run_in ? 1'b0 : 1'b1;
                        st_r <= sarcc_pkg::SARCC_HS_IDLE;
                    end else cnt_r <= cnt_r - 8'h01;
                end
                sarcc_pkg::SARCC_HS_READ: begin
                    if (cnt_r == 8'h00) begin
                        result_out <= bus.data_o;
                        result_valid_out <= 1'b1;
                        bus.rd_n <= 1'b1;
                        bus.cs_n <= 1'b1;
                        st_r <= sarcc_pkg::SARCC_HS_IDLE;
                    end else cnt_r <= cnt_r - 8'h01;
                end
                default: st_r <= sarcc_pkg::SARCC_HS_IDLE;
            endcase
        end
    end
endmodule : sarcc_host

// *** sarcc_if.sv ***
// Interface joining the converter control and its host
`timescale 1ns/1ps
interface sarcc_if;
    logic cs_n;
    logic start_n;
    logic rd_n;
    logic done_flag_n;
    logic [7:0] data_o;
    logic [7:0] data_oe_n;
    modport dev (input cs_n, input start_n, input rd_n, output done_flag_n,
        output data_o, output data_oe_n);
    modport host (output cs_n, output start_n, output rd_n, input done_flag_n,
        input data_o, input data_oe_n);
endinterface : sarcc_if

// *** sarcc_pkg.sv ***
// Package of shared constants and types for the APPROX_REGISTER conversion control pair
package sarcc_pkg;
    // ------------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------------
    localparam int RES_BITS = 8;
    localparam logic [7:0] FULL_SCALE = 8'hff;
    localparam int CLK_NS = 50;
    // Conversion clock divider: sys_clk cycles per conversion-clock period
    localparam logic [7:0] CONV_DIV = 8'h04;
    // Internal phase clock runs at one eighth of the conversion clock
    localparam logic [2:0] PHASE_DIV = 3'h7;
    // Eight comparisons of eight conversion clocks each
    localparam int CMP_CLKS = 8;
    localparam int CONV_CLKS = 64;
    // Done flag cannot be cleared by a read for this many conversion clocks
    localparam logic [3:0] DONE_HOLD = 4'h8;
    // Host read guard after done
    localparam logic [3:0] READ_GUARD = 4'h8;
    // Free-running done pulse width
    localparam int DONE_PULSE_NS = 300;
    localparam logic [3:0] DONE_PULSE_CYC = 4'((DONE_PULSE_NS + CLK_NS - 1) / CLK_NS);
    // Host state encodings
    typedef enum logic [2:0] {
        SARCC_HS_IDLE = 3'b001,
        SARCC_HS_START = 3'b010,
        SARCC_HS_READ = 3'b100
    } sarcc_hstate_type;
endpackage : sarcc_pkg

// *** sarcc_props.sv ***
// Concurrent checks on the strobes, done flag and data lines between the two ends
`timescale 1ns/1ps
module sarcc_props #(
    parameter logic [7:0] CONV_DIV = sarcc_pkg::CONV_DIV
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic cs_n,
    input wire logic start_n,
    input wire logic rd_n,
    input wire logic done_flag_n,
    input wire logic [7:0] data_o,
    input wire logic [7:0] data_oe_n
);
    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    // Start released with select low, then left alone
    sequence release_s;
        $rose(start_n) && !cs_n ##1 start_n[*8];
    endsequence
    // Done just asserted and nobody starting or reading
    sequence quiet_done_s;
        $fell(done_flag_n) ##1 (start_n && (cs_n || rd_n))[*7];
    endsequence
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    // Strobes pass a synchroniser, so six quiet cycles are allowed for
    oe_off_a: assert property ((cs_n || rd_n)[*6] |-> data_oe_n == 8'hff)
        else $error("data driven without select and read");
    oe_on_a: assert property ((!cs_n && !rd_n)[*6] |-> data_oe_n == 8'h00)
        else $error("data not driven during read");
    held_start_a: assert property ((!cs_n && !start_n)[*8] |-> done_flag_n)
        else $error("done low while start held");
    latch_first_a: assert property ($fell(done_flag_n) |->
        $stable(data_o) && data_o == $past(data_o, 2))
        else $error("data changed as done asserted");
    done_hold_a: assert property (quiet_done_s |-> !done_flag_n)
        else $error("done released too early");
    read_clear_a: assert property (!cs_n && !rd_n && !done_flag_n |->
        ##[1:12] done_flag_n)
        else $error("read did not clear done");
    conv_time_a: assert property (release_s |-> ##[80:600] $fell(done_flag_n))
        else $error("conversion time out of range");
    boot_pulse_a: assert property ($rose(resetn_in) |-> ##[0:8] !start_n)
        else $error("no start pulse after reset");
endmodule : sarcc_props

// *** sarcc_tb_top.sv ***
// Self-checking bench joining the converter end and the host end
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("FAIL %0t %s", $time, msg); end end
module sarcc_tb_top;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    localparam logic [7:0] DIV = 8'h02; // Short conversion clock keeps the run brief
    logic sys_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic cmp_above_in = 1'b0;
    logic start_req_in = 1'b0;
    logic free_run_in = 1'b0;
    logic [7:0] trial_code_out;
    logic busy_out;
    logic [7:0] result_out;
    logic result_valid_out;
    logic [7:0] target = 8'h00;
    logic [7:0] vals [4] = '{8'h00, 8'hff, 8'ha5, 8'h5a};
    int miscompares = 0;
    int num_checks = 0;
    sarcc_if sv();
    sarcc_device #(.CONV_DIV(DIV)) sarcc_device_i (.sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in), .bus(sv), .cmp_above_in(cmp_above_in),
        .trial_code_out(trial_code_out), .busy_out(busy_out));
    sarcc_host #(.CONV_DIV(DIV)) sarcc_host_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .bus(sv), .start_req_in(start_req_in), .free_run_in(free_run_in),
        .result_out(result_out), .result_valid_out(result_valid_out));
    sarcc_props #(.CONV_DIV(DIV)) sarcc_props_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .cs_n(sv.cs_n), .start_n(sv.start_n), .rd_n(sv.rd_n), .done_flag_n(sv.done_flag_n),
        .data_o(sv.data_o), .data_oe_n(sv.data_oe_n));
    // Clock at 20 MHz
    initial begin
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    // Comparator stand-in: input counts as above when it reaches the trial code
    always @(negedge sys_clk_in) begin
        cmp_above_in <= (target >= trial_code_out);
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    // Bounded wait for the one-cycle result pulse, seen at the falling edge
    task automatic wait_valid(output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 1500 && !ok; i++) begin
            @(negedge sys_clk_in);
            ok = (result_valid_out === 1'b1);
        end
    endtask : wait_valid
    task automatic pulse_start(input logic [7:0] val);
        @(negedge sys_clk_in);
        target = val;
        start_req_in = 1'b1;
        @(negedge sys_clk_in);
        start_req_in = 1'b0;
    endtask : pulse_start
    task automatic test_convert(input logic [7:0] val);
        logic ok;
        pulse_start(val);
        wait_valid(ok);
        `CHK(ok, 1'b1, "no result")
        `CHK(result_out, val, "wrong code")
        repeat (20) @(negedge sys_clk_in);
        `CHK(sv.done_flag_n, 1'b1, "done not cleared by read")
        `CHK(sv.data_oe_n, 8'hff, "data left driven")
        $display("test convert %h done", val);
    endtask : test_convert
    // Done fed back as start: each completion must launch the next conversion
    task automatic test_free_run();
        int cnt;
        logic prev;
        cnt = 0;
        prev = 1'b1;
        @(negedge sys_clk_in);
        free_run_in = 1'b1;
        // Free run needs one kick before the fed-back done takes over
        pulse_start(8'h3c);
        for (int i = 0; i < 1500 && cnt < 4; i++) begin
            @(negedge sys_clk_in);
            if (prev === 1'b1 && sv.done_flag_n === 1'b0) begin
                cnt++;
                `CHK(sv.data_o, 8'h3c, "free run code")
                repeat (16) @(negedge sys_clk_in);
                `CHK(sv.done_flag_n, 1'b1, "free run done not cleared")
            end
            prev = sv.done_flag_n;
        end
        `CHK(cnt, 4, "free run stalled")
        free_run_in = 1'b0;
        repeat (600) @(negedge sys_clk_in);
        $display("test free run done");
    endtask : test_free_run
    // Reset in mid-conversion, then the boot start must bring a fresh result
    task automatic test_reset();
        logic ok;
        pulse_start(8'hc3);
        repeat (60) @(negedge sys_clk_in);
        resetn_in = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        `CHK(sv.done_flag_n, 1'b1, "done after reset")
        `CHK(sv.data_oe_n, 8'hff, "enable after reset")
        `CHK(sv.data_o, 8'h00, "data after reset")
        `CHK(busy_out, 1'b0, "busy after reset")
        resetn_in = 1'b1;
        wait_valid(ok);
        `CHK(ok, 1'b1, "no boot conversion")
        `CHK(result_out, 8'hc3, "boot code")
        $display("test reset done");
    endtask : test_reset
    // Power-up start pulse from the host must bring a first result
    task automatic test_boot();
        logic ok;
        wait_valid(ok);
        `CHK(ok, 1'b1, "no boot conversion")
        `CHK(result_out, 8'h00, "boot code")
        repeat (20) @(negedge sys_clk_in);
        $display("test boot done");
    endtask : test_boot
    // A second start in mid-conversion must abort and bring the new code
    task automatic test_abort();
        logic ok;
        pulse_start(8'h11);
        repeat (100) @(negedge sys_clk_in);
        `CHK(busy_out, 1'b1, "not busy mid-conversion")
        pulse_start(8'h9c);
        repeat (8) @(negedge sys_clk_in);
        `CHK(trial_code_out, 8'h00, "approximation not cleared")
        wait_valid(ok);
        `CHK(ok, 1'b1, "no result after abort")
        `CHK(result_out, 8'h9c, "abort code")
        repeat (20) @(negedge sys_clk_in);
        $display("test abort done");
    endtask : test_abort
    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(negedge sys_clk_in);
        resetn_in = 1'b1;
        test_boot();
        foreach (vals[i]) begin
            test_convert(vals[i]);
        end
        test_free_run();
        test_convert(8'h81);
        test_abort();
        test_reset();
        report_and_stop();
    end
    // Whole run needs under 10000 cycles; three times that means a hang
    initial begin
        repeat (30000) @(posedge sys_clk_in);
        miscompares++;
        report_and_stop();
    end
endmodule : sarcc_tb_top
